// ==== design/tss_top.sv ====
// trip source select: avalon-mm register bank, one-shot trip latch,
// forced pwm output drive and a level interrupt
// assumes trip pins and comparator events already synchronous to clk,
// and a single-pulse trip_flag_clear from the wider trip unit
//
// Notes on behaviour
// (R1) The select register's upper byte holds one one-shot enable per trip source.
// (R2) Any enabled trip pin going low, or enabled comparator event going high, raises a one-shot trip event.
// (R3) A one-shot trip forces outputs a and b to the programmed trip actions.
// (R4) The trip stays latched despite sources recovering, until the clear is written.
// (R5) Bit 15 enables comparator b event one as a one-shot source when set.
// (R6) Bit 14 enables comparator a event one as a one-shot source when set.
// (R7) Bit 13 enables trip input 6 as a one-shot source when set.
// (R8) Bit 12 enables trip input 5 as a one-shot source when set.
// (R9) Bits 11 to 8 enable trip inputs 4 to 1 as one-shot sources when set.
// (R10) The lower byte is kept as writable configuration for the rest of the unit.
`timescale 1ns/1ps
`default_nettype none
`include "tss_cfg.svh"

module tss_top
  import tss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // trip sources, pins active low
  input wire logic trip_in_1,
  input wire logic trip_in_2,
  input wire logic trip_in_3,
  input wire logic trip_in_4,
  input wire logic trip_in_5,
  input wire logic trip_in_6,
  // comparator events, asserted high
  input wire logic cmp_a_event_one,
  input wire logic cmp_b_event_one,
  // wider trip unit: action control and clear
  input wire tss_action_t trip_action_control,
  input wire logic trip_flag_clear,
  // pwm path, from upstream and to the pins
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  output logic pwm_out_a,
  output logic pwm_oe_a,
  output logic pwm_out_b,
  output logic pwm_oe_b,
  // status
  output logic [7:0] cycle_trip_en,
  output logic oneshot_tripped,
  output logic irq
);

  // merge two byte lanes into a 16-bit register value
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // map one trip action onto the upstream level
  function automatic tss_drive_t apply_action(input logic [1:0] act,
                                              input logic level);
    tss_drive_t d;
    d.oe = 1'b1;
    d.val = level;
    case (act)
      `TSS_ACT_RELEASE: d.oe = 1'b0;
      `TSS_ACT_HIGH: d.val = 1'b1;
      `TSS_ACT_LOW: d.val = 1'b0;
      `TSS_ACT_NONE: d.val = level;
      default: d.val = level;
    endcase
    return d;
  endfunction

  // state
  logic [15:0] trip_source_select;
  logic [15:0] next_select;
  logic [`TSS_IRQ_WIDTH-1:0] irq_status;
  logic [`TSS_IRQ_WIDTH-1:0] next_irq_status;
  logic [`TSS_IRQ_WIDTH-1:0] irq_mask;
  logic [`TSS_IRQ_WIDTH-1:0] next_irq_mask;
  logic latched;
  logic next_latched;
  tss_bus_state_t bus_state;
  tss_bus_state_t next_bus_state;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  tss_drive_t drive_a;
  tss_drive_t drive_b;
  tss_drive_t next_drive_a;
  tss_drive_t next_drive_b;
  logic [7:0] src_prev;
  logic [7:0] next_src_prev;

  // combinational helpers
  tss_src_t asserted;
  tss_src_t enabled_hit;
  logic trip_event;
  logic new_source;
  logic req;
  logic accept;
  logic wr_sel;
  logic wr_status;
  logic wr_mask;

  // source levels turned to asserted-high; pins trip when low
  always_comb begin
    asserted.cmp_b_event_one = cmp_b_event_one;
    asserted.cmp_a_event_one = cmp_a_event_one;
    asserted.trip_in_6 = ~trip_in_6; // R7
    asserted.trip_in_5 = ~trip_in_5; // R8
    asserted.trip_in_4 = ~trip_in_4; // R9
    asserted.trip_in_3 = ~trip_in_3; // R9
    asserted.trip_in_2 = ~trip_in_2; // R9
    asserted.trip_in_1 = ~trip_in_1; // R9
  end

  // upper byte gates each source, one bit per source
  always_comb begin
    enabled_hit = asserted & trip_source_select[`TSS_SEL_OSHT_HI:`TSS_SEL_OSHT_LO]; // R1
    enabled_hit.cmp_b_event_one = asserted.cmp_b_event_one &
                                  trip_source_select[`TSS_SEL_CMP_B1]; // R5
    enabled_hit.cmp_a_event_one = asserted.cmp_a_event_one &
                                  trip_source_select[`TSS_SEL_CMP_A1]; // R6
    trip_event = |enabled_hit; // R2
    // an enabled source newly asserted since the last cycle, first one included, for the second status bit
    new_source = |(enabled_hit & ~src_prev);
  end

  // bus decode; one wait state so readdata can come from a flop
  always_comb begin
    req = avs_read | avs_write;
    accept = req && (bus_state == TSS_BUS_IDLE);
    avs_waitrequest = req && (bus_state != TSS_BUS_ANSWER);
    wr_sel = accept && avs_write && (avs_address == `TSS_OFS_SELECT);
    wr_status = accept && avs_write && (avs_address == `TSS_OFS_IRQ_STATUS);
    wr_mask = accept && avs_write && (avs_address == `TSS_OFS_IRQ_MASK);
  end

  // handshake state: idle takes the request, answer releases it
  always_comb begin
    case (bus_state)
      TSS_BUS_IDLE: next_bus_state = req ? TSS_BUS_ANSWER : TSS_BUS_IDLE;
      TSS_BUS_ANSWER: next_bus_state = TSS_BUS_IDLE;
      default: next_bus_state = TSS_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_state <= TSS_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // read data captured at acceptance, shown while waitrequest is low
  always_comb begin
    next_rdata = rdata;
    if (accept && avs_read) begin
      case (avs_address)
        `TSS_OFS_SELECT: next_rdata = {16'h0000, trip_source_select};
        `TSS_OFS_IRQ_STATUS: next_rdata = {30'h00000000, irq_status};
        `TSS_OFS_IRQ_MASK: next_rdata = {30'h00000000, irq_mask};
        `TSS_OFS_TRIP_STATE: begin
          next_rdata = 32'h00000000;
          next_rdata[`TSS_ST_LATCHED] = latched;
          next_rdata[`TSS_ST_LIVE_LO +: 8] = asserted;
        end
        default: next_rdata = 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign avs_readdata = rdata;

  // select register, all sixteen bits writable
  always_comb begin
    next_select = trip_source_select;
    if (wr_sel) begin
      next_select = merge16(trip_source_select, avs_writedata, avs_byteenable); // R10
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trip_source_select <= `TSS_RST_SELECT;
    end else begin
      trip_source_select <= next_select;
    end
  end

  // lower byte only configures the cycle trip logic elsewhere
  assign cycle_trip_en = trip_source_select[`TSS_SEL_OSHT_LO-1:0]; // R10

  // one-shot latch; a fresh event beats a clear in the same cycle
  always_comb begin
    next_latched = latched;
    if (trip_flag_clear) begin
      next_latched = 1'b0; // R4
    end
    if (trip_event) begin
      next_latched = 1'b1; // R4
    end
    next_src_prev = enabled_hit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latched <= 1'b0;
      src_prev <= 8'h00;
    end else begin
      latched <= next_latched;
      src_prev <= next_src_prev;
    end
  end

  assign oneshot_tripped = latched;

  // forced drive tracks the latch's next value, so a clear frees the pins with it
  always_comb begin
    next_drive_a.oe = 1'b1;
    next_drive_a.val = pwm_in_a;
    next_drive_b.oe = 1'b1;
    next_drive_b.val = pwm_in_b;
    if (next_latched) begin
      next_drive_a = apply_action(trip_action_control.act_a, pwm_in_a); // R3
      next_drive_b = apply_action(trip_action_control.act_b, pwm_in_b); // R3
    end
  end

  // outputs registered so a short glitch on pwm_in never reaches the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_a <= 2'b00;
      drive_b <= 2'b00;
    end else begin
      drive_a <= next_drive_a;
      drive_b <= next_drive_b;
    end
  end

  assign pwm_out_a = drive_a.val;
  assign pwm_oe_a = drive_a.oe;
  assign pwm_out_b = drive_b.val;
  assign pwm_oe_b = drive_b.oe;

  // sticky status: write one clears, a same-cycle event still sets
  always_comb begin
    next_irq_status = irq_status;
    if (wr_status && avs_byteenable[0]) begin
      next_irq_status = irq_status & ~avs_writedata[`TSS_IRQ_WIDTH-1:0];
    end
    if (trip_event && !latched) begin
      next_irq_status[`TSS_IRQ_ONESHOT] = 1'b1;
    end
    if (new_source) begin
      next_irq_status[`TSS_IRQ_SOURCE] = 1'b1;
    end
  end

  // mask register, same layout as the status
  always_comb begin
    next_irq_mask = irq_mask;
    if (wr_mask && avs_byteenable[0]) begin
      next_irq_mask = avs_writedata[`TSS_IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status <= `TSS_RST_IRQ;
      irq_mask <= `TSS_RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // level interrupt, no extra flop so clearing drops it at once
  assign irq = |(irq_status & irq_mask);

endmodule // tss_top

`default_nettype wire

// ==== include/tss_cfg.svh ====
// trip source select block: offsets, field positions, reset values, codes
// assumes inclusion by the design, checker and bench files; the package does not include it
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

// register byte addresses on the word-aligned slave port
`define TSS_OFS_SELECT 4'h0
`define TSS_OFS_IRQ_STATUS 4'h4
`define TSS_OFS_IRQ_MASK 4'h8
`define TSS_OFS_TRIP_STATE 4'hc

// select register fields
`define TSS_SEL_OSHT_HI 15
`define TSS_SEL_OSHT_LO 8
`define TSS_SEL_CMP_B1 15
`define TSS_SEL_CMP_A1 14
`define TSS_SEL_ZONE6 13
`define TSS_SEL_ZONE5 12
`define TSS_SEL_ZONE1 8

// interrupt status / mask fields
`define TSS_IRQ_ONESHOT 0
`define TSS_IRQ_SOURCE 1
`define TSS_IRQ_WIDTH 2

// trip state readback fields
`define TSS_ST_LATCHED 0
`define TSS_ST_LIVE_LO 8

// reset values
`define TSS_RST_SELECT 16'h0000
`define TSS_RST_IRQ 2'h0

// trip action codes, two bits per output
`define TSS_ACT_RELEASE 2'h0
`define TSS_ACT_HIGH 2'h1
`define TSS_ACT_LOW 2'h2
`define TSS_ACT_NONE 2'h3

`endif

// ==== include/tss_pkg.sv ====
// trip source select block: shared types
// numeric constants live in tss_cfg.svh
package tss_pkg;

  // one bit per one-shot trip source, in select register order
  typedef struct packed {
    logic cmp_b_event_one;
    logic cmp_a_event_one;
    logic trip_in_6;
    logic trip_in_5;
    logic trip_in_4;
    logic trip_in_3;
    logic trip_in_2;
    logic trip_in_1;
  } tss_src_t;

  // forced pin drive for one output
  typedef struct packed {
    logic oe;
    logic val;
  } tss_drive_t;

  // action pair from the trip action control register
  typedef struct packed {
    logic [1:0] act_b;
    logic [1:0] act_a;
  } tss_action_t;

  // bus handshake states, gray along idle -> answer
  typedef enum logic [1:0] {
    TSS_BUS_IDLE = 2'b00,
    TSS_BUS_ANSWER = 2'b01
  } tss_bus_state_t;

endpackage

// ==== verif/tss_checker.sv ====
// checker for tss_top: trip latch, forced drive, bus timing
// assumes the cfg header on the include path; bound to tss_top below
`timescale 1ns/1ps
`default_nettype none
`include "tss_cfg.svh"
module tss_checker
  import tss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // sources
  input wire logic trip_in_1,
  input wire logic trip_in_2,
  input wire logic trip_in_3,
  input wire logic trip_in_4,
  input wire logic trip_in_5,
  input wire logic trip_in_6,
  input wire logic cmp_a_event_one,
  input wire logic cmp_b_event_one,
  // action, clear, pwm path, status
  input wire tss_action_t trip_action_control,
  input wire logic trip_flag_clear,
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  input wire logic pwm_out_a,
  input wire logic pwm_oe_a,
  input wire logic pwm_out_b,
  input wire logic pwm_oe_b,
  input wire logic [7:0] cycle_trip_en,
  input wire logic oneshot_tripped
);
  logic [15:0] sel, next_sel;
  logic up, next_up, up0, next_up0;
  logic [7:0] live;
  logic ev;
  // shadow select, updated on the taking edge like the design
  always_comb begin
    next_sel = sel;
    next_up0 = 1'b1;
    next_up = up0;
    if (avs_write && avs_waitrequest && avs_address == `TSS_OFS_SELECT) begin
      if (avs_byteenable[0]) next_sel[7:0] = avs_writedata[7:0];
      if (avs_byteenable[1]) next_sel[15:8] = avs_writedata[15:8];
    end
  end
  // up skips the first edge, where outputs still hold reset values;
  // two flops since disable iff reads current, not sampled, values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel <= `TSS_RST_SELECT;
      up0 <= 1'b0;
      up <= 1'b0;
    end else begin
      sel <= next_sel;
      up0 <= next_up0;
      up <= next_up;
    end
  end
  // pins low or events high, in select order
  assign live = {cmp_b_event_one, cmp_a_event_one, ~trip_in_6, ~trip_in_5,
                 ~trip_in_4, ~trip_in_3, ~trip_in_2, ~trip_in_1};
  assign ev = |(live & sel[15:8]);
  function automatic logic aok(input logic [1:0] a, input logic p, input logic oe,
                               input logic v);
    return oe == (a != `TSS_ACT_RELEASE) && (a == `TSS_ACT_RELEASE ||
           v == (a == `TSS_ACT_NONE ? p : a == `TSS_ACT_HIGH));
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!up);
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd_ans;
    avs_read && !avs_waitrequest;
  endsequence
  AST_TRIP_SET: assert property (ev |=> oneshot_tripped)
    else $error("trip not latched");
  AST_NO_SPUR: assert property (!oneshot_tripped && !ev |=> !oneshot_tripped)
    else $error("trip without enabled source");
  AST_HOLD: assert property (oneshot_tripped && (!trip_flag_clear || ev) |=> oneshot_tripped)
    else $error("trip released early");
  AST_CLEAR: assert property (oneshot_tripped && trip_flag_clear && !ev |=> !oneshot_tripped)
    else $error("clear ignored");
  AST_FORCE: assert property (oneshot_tripped |->
    aok($past(trip_action_control.act_a), $past(pwm_in_a), pwm_oe_a, pwm_out_a) &&
    aok($past(trip_action_control.act_b), $past(pwm_in_b), pwm_oe_b, pwm_out_b))
    else $error("forced drive wrong");
  AST_PASS: assert property (!oneshot_tripped |-> pwm_oe_a && pwm_oe_b &&
    pwm_out_a == $past(pwm_in_a) && pwm_out_b == $past(pwm_in_b))
    else $error("pass-through wrong");
  AST_WAIT: assert property (s_take |=> !avs_waitrequest)
    else $error("no answer after one wait");
  AST_SEL_RD: assert property (s_rd_ans and avs_address == `TSS_OFS_SELECT |->
    avs_readdata == {16'h0, sel})
    else $error("select readback wrong");
  AST_LOW: assert property (cycle_trip_en == sel[7:0])
    else $error("low byte not passed on");
  AST_UNMAP: assert property (s_rd_ans and avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // tss_checker
bind tss_top tss_checker u_chk (.clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .trip_in_1,
  .trip_in_2, .trip_in_3, .trip_in_4, .trip_in_5, .trip_in_6, .cmp_a_event_one,
  .cmp_b_event_one, .trip_action_control, .trip_flag_clear, .pwm_in_a, .pwm_in_b,
  .pwm_out_a, .pwm_oe_a, .pwm_out_b, .pwm_oe_b, .cycle_trip_en, .oneshot_tripped);
`default_nettype wire

// ==== verif/tss_src_model.sv ====
// trip source model: six pins and two comparator events
// assumes want changes just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module tss_src_model
  import tss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sources to assert, and a slower answer
  input wire tss_src_t want,
  input wire logic slow,
  // pins active low, events active high
  output tss_src_t pins
);
  tss_src_t q1, q2;
  // two stages so the bench can try a late source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q1 <= '0;
      q2 <= '0;
    end else begin
      q1 <= want;
      q2 <= q1;
    end
  end
  // released pins return high, as if pulled up
  assign pins = (slow ? q2 : q1) ^ 8'h3f;
endmodule // tss_src_model
`default_nettype wire

// ==== verif/trip_source_select_tb_top.sv ====
// bench for tss_top: bus, trip latch, forced drive, interrupt
// assumes the source model and checker compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "tss_cfg.svh"
module trip_source_select_tb_top;
  import tss_pkg::*;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, trip_flag_clear = 0;
  logic pwm_in_a = 0, pwm_in_b = 0, slow = 0, pa, pb, avs_waitrequest, irq;
  logic pwm_out_a, pwm_oe_a, pwm_out_b, pwm_oe_b, oneshot_tripped;
  logic [3:0] avs_address = '0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [7:0] cycle_trip_en;
  logic [15:0] sel;
  logic [16:0] rnd = 17'd65691;
  tss_action_t trip_action_control = '0;
  tss_src_t want = '0, pins;
  int mismatches = 0, comparisons = 0, cyc = 0;
  tss_top dut (.*, .trip_in_1(pins.trip_in_1), .trip_in_2(pins.trip_in_2),
    .trip_in_3(pins.trip_in_3), .trip_in_4(pins.trip_in_4), .trip_in_5(pins.trip_in_5),
    .trip_in_6(pins.trip_in_6), .cmp_a_event_one(pins.cmp_a_event_one),
    .cmp_b_event_one(pins.cmp_b_event_one));
  tss_src_model src (.clk, .rst, .want, .slow, .pins);
  always #50 clk = ~clk;
  function automatic logic [16:0] lf(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  // random upstream pwm, last-edge copies, hang guard
  always @(posedge clk) begin
    rnd <= lf(rnd);
    pwm_in_a <= rnd[0];
    pwm_in_b <= rnd[5];
    pa <= pwm_in_a;
    pb <= pwm_in_b;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // holds the request until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic dchk(input logic [1:0] a, input logic p, input logic oe, input logic v);
    check("drive_oe", oe, a != `TSS_ACT_RELEASE);
    if (a != `TSS_ACT_RELEASE) check("drive_val", v, a == `TSS_ACT_NONE ? p : a == 2'h1);
  endtask
  task final_report;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    bus(0, `TSS_OFS_SELECT, 0, q);
    check("sel_rst", q, 32'h0);
    bus(1, 4'h2, 32'hffff, q);
    bus(0, 4'h2, 0, q);
    check("unmapped", q, 32'h0);
    // one enabled source per pass, all others asserted first
    for (int i = 0; i < 8; i++) begin
      sel = {8'h01 << i, rnd[7:0]};
      bus(1, `TSS_OFS_SELECT, {16'h0, sel}, q);
      bus(0, `TSS_OFS_SELECT, 0, q);
      check("sel_rd", q, {16'h0, sel});
      check("cycle_en", cycle_trip_en, sel[7:0]);
      bus(1, `TSS_OFS_IRQ_MASK, i % 2, q);
      trip_action_control <= rnd[3:0];
      slow <= rnd[9];
      want <= ~(8'h01 << i);
      tick(3);
      check("no_trip", oneshot_tripped, 0);
      @(posedge clk);
      want <= 8'hff;
      tick(3);
      check("trip", oneshot_tripped, 1);
      check("irq", irq, i % 2);
      dchk(trip_action_control.act_a, pa, pwm_oe_a, pwm_out_a);
      dchk(trip_action_control.act_b, pb, pwm_oe_b, pwm_out_b);
      bus(0, `TSS_OFS_IRQ_STATUS, 0, q);
      check("irq_status", q, 32'h3);
      bus(0, `TSS_OFS_IRQ_MASK, 0, q);
      check("irq_mask", q, i % 2);
      bus(0, `TSS_OFS_TRIP_STATE, 0, q);
      check("trip_state", q, 32'h0000ff01);
      @(posedge clk);
      trip_flag_clear <= 1;
      @(posedge clk);
      trip_flag_clear <= 0;
      want <= 0;
      tick(3);
      check("held", oneshot_tripped, 1);
      @(posedge clk);
      trip_flag_clear <= 1;
      @(posedge clk);
      trip_flag_clear <= 0;
      tick(1);
      check("cleared", oneshot_tripped, 0);
      dchk(`TSS_ACT_NONE, pa, pwm_oe_a, pwm_out_a);
      dchk(`TSS_ACT_NONE, pb, pwm_oe_b, pwm_out_b);
      @(posedge clk);
      bus(1, `TSS_OFS_IRQ_STATUS, 32'h3, q);
      @(negedge clk);
      check("irq_clr", irq, 0);
      @(posedge clk);
    end
    final_report;
  end
endmodule // trip_source_select_tb_top
`default_nettype wire
